/* File: logic/smi_group.sv */
// Group system-management interrupt collector with dual-edge GPIO status
//
// Function
// - Status2 bits 0,1: mouse, keyboard, source-cleared
// - Status2 bit 2: infrared transition, clear-on-read
// - Status2 bit 3: sticky event, clear-on-read
// - Status2 bit 4: controller port bit; 5,6 reserved
// - Status2 bit 7: sleep-request SMI, clear-on-read
// - Enable1 bits gate eight sources onto output
// - Ring uses wake status bit as SMI status
// - Enable2 bits 0-3,5 gate their sources
// - Enable2 bit 4 routes controller port bit
// - Consumer infrared uses wake status bit
// - Enable2 bit 6 feeds output to wake logic
// - Enable2 bit 7 drives pin, else floats
// - Multiplexer bit picks pin or serial slot
// - Dual-edge pins interrupt on both edges
// - Dual-edge needs its group interrupt enabled
// - Dual-edge ignores direction; polarity inverts readback
// - Dual-edge interrupt needs status and enable
// - Status records edges regardless of mode
// - Misc bits 0-3 follow pins 11,12,53,54
// - Edge and power-on bits clear on one
// - Misc bit 4 standby power-on, raises SCI
// - Misc bits 5-7 read zero
// - Status1 bits 1-4,7 source-cleared; 5,6 also carry dual-edge interrupts, cleared in Misc; bit 0 reserved
module smi_group (
	// Clock and reset
	input  wire logic            REF_CLK,
	input  wire logic            RST_N,
	// Host I/O access
	input  smi_pkg::io_req_t     IO_REQ,
	output logic [7:0]           IO_RDATA,
	output logic                 IO_HIT,
	// Interrupt sources and events
	input  smi_pkg::src_t        SRC,
	input  smi_pkg::evt_t        EVT,
	// Dual-edge GPIO
	input  wire logic            GPIO_PIN_11,
	input  wire logic            GPIO_PIN_12,
	input  wire logic            GPIO_PIN_53,
	input  wire logic            GPIO_PIN_54,
	input  wire logic [3:0]      DUAL_EDGE_IRQ_MODE,
	input  wire logic [3:0]      DUAL_EDGE_POLARITY,
	output logic [3:0]           DUAL_EDGE_READBACK,
	output logic [3:0]           DUAL_EDGE_IRQ,
	// Power state
	input  wire logic            SYSTEM_ON_N,
	output logic                 STANDBY_SCI,
	// Output routing
	input  wire logic            SERIAL_IRQ_SELECT,
	output logic                 GROUP_MGMT_IRQ_N_O,
	output logic                 GROUP_MGMT_IRQ_N_OE,
	output logic                 SERIAL_IRQ2_REQ,
	output logic                 SMI_TO_WAKE
);
	logic [7:0] en1_q;
	logic [7:0] en2_q;
	logic       ir_q;
	logic       bit3_q;
	logic       sleep_q;
	logic       por_q;
	logic       por_sci_q;
	logic       sys_on_q;
	logic [3:0] edge_flag_q;
	logic [3:0] edge_pin;
	logic [7:0] sts1;
	logic [7:0] sts2;
	logic [7:0] misc;
	logic       rd_sts2;
	logic       wr_misc;
	logic       any_smi;
	logic       group_irq_a;
	logic       group_irq_b;
	logic       group_active;
	logic [7:0] rdata_d;
	// Register decode, one select per register
	logic       sel_sts1;
	logic       sel_sts2;
	logic       sel_en1;
	logic       sel_en2;
	logic       sel_misc;
	logic       wr_en1;
	logic       wr_en2;
	// Named fields of the status views
	logic       mouse_irq_flag;
	logic       keybd_irq_flag;
	logic       infrared_edge_flag;
	logic       bit3_event_flag;
	logic       kbc_port1_bit2;
	logic       sleep_request_smi_flag;
	logic       standby_por_flag;
	logic [3:0] dual_edge_flag;
	// Named enable bits, first register then second
	logic       ring_smi_enable;
	logic       parport_smi_enable;
	logic       uart_b_smi_enable;
	logic       uart_a_smi_enable;
	logic       floppy_smi_enable;
	logic       gpio_grp_b_smi_enable;
	logic       gpio_grp_a_smi_enable;
	logic       watchdog_smi_enable;
	logic       mouse_smi_enable;
	logic       keybd_smi_enable;
	logic       infrared_smi_enable;
	logic       bit3_smi_enable;
	logic       kbc_pin_route_enable;
	logic       consumer_ir_smi_enable;
	logic       smi_to_wake_enable;
	logic       smi_output_enable;
	// One term per source that can pull the group output
	logic [7:0] smi_term_1;
	logic [7:0] smi_term_2;
	// Routed copies of the group output
	logic       smi_pin_drive;
	logic       smi_slot_drive;

	// Dual-edge pins, bit 0 is pin 11
	assign edge_pin = {GPIO_PIN_54, GPIO_PIN_53, GPIO_PIN_12, GPIO_PIN_11};

	// Register decode; other offsets select nothing
	assign sel_sts1 = (IO_REQ.addr == smi_pkg::SMI_STS1_OFS);
	assign sel_sts2 = (IO_REQ.addr == smi_pkg::SMI_STATUS_2_OFS);
	assign sel_en1  = (IO_REQ.addr == smi_pkg::SMI_ENABLE_1_OFS);
	assign sel_en2  = (IO_REQ.addr == smi_pkg::SMI_ENABLE_2_OFS);
	assign sel_misc = (IO_REQ.addr == smi_pkg::MISC_STS_OFS);
	// Strobes qualified by the decode; of the status views only misc takes writes, one to clear
	assign rd_sts2  = IO_REQ.rd && sel_sts2;
	assign wr_misc  = IO_REQ.wr && sel_misc;
	assign wr_en1   = IO_REQ.wr && sel_en1;
	assign wr_en2   = IO_REQ.wr && sel_en2;

	// First enable register
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			en1_q <= smi_pkg::EN1_RST;
		end else if (wr_en1) begin
			en1_q <= IO_REQ.wdata;
		end
	end

	// Second enable register
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			en2_q <= smi_pkg::EN2_RST;
		end else if (wr_en2) begin
			en2_q <= IO_REQ.wdata;
		end
	end

	// First register: one enable per source, ring at bit 0
	assign ring_smi_enable       = en1_q[0];
	assign parport_smi_enable    = en1_q[1];
	assign uart_b_smi_enable     = en1_q[2];
	assign uart_a_smi_enable     = en1_q[3];
	assign floppy_smi_enable     = en1_q[4];
	assign gpio_grp_b_smi_enable = en1_q[5];
	assign gpio_grp_a_smi_enable = en1_q[6];
	assign watchdog_smi_enable   = en1_q[7];
	// Second register: source enables
	assign mouse_smi_enable       = en2_q[smi_pkg::EN2_MOUSE];
	assign keybd_smi_enable       = en2_q[smi_pkg::EN2_KEYBD];
	assign infrared_smi_enable    = en2_q[smi_pkg::EN2_IR];
	assign bit3_smi_enable        = en2_q[smi_pkg::EN2_BIT3];
	assign kbc_pin_route_enable   = en2_q[smi_pkg::EN2_KBC];
	assign consumer_ir_smi_enable = en2_q[smi_pkg::EN2_CIR];
	// Second register: where the group output goes
	assign smi_to_wake_enable     = en2_q[smi_pkg::EN2_TO_WAKE];
	assign smi_output_enable      = en2_q[smi_pkg::EN2_OUT];

	// Infrared transition flag; an edge in the read cycle survives the read
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ir_q <= 1'b0;
		end else begin
			ir_q <= EVT.infrared_edge | (ir_q & ~rd_sts2);
		end
	end

	// Bit-3 event flag, sticky until the status read
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bit3_q <= 1'b0;
		end else begin
			bit3_q <= EVT.bit3_event | (bit3_q & ~rd_sts2);
		end
	end

	// Sleep-request flag; set wins so no request is lost to a read
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sleep_q <= 1'b0;
		end else begin
			sleep_q <= EVT.sleep_request_smi | (sleep_q & ~rd_sts2);
		end
	end

	// Dual-edge flags, one per pin
	genvar g;
	generate
		for (g = 0; g < smi_pkg::NUM_EDGE; g++) begin : g_edge
			edge_flag u_flag (
				.REF_CLK (REF_CLK),
				.RST_N   (RST_N),
				.pin     (edge_pin[g]),
				.clr     (wr_misc & IO_REQ.wdata[g]),
				.flag_q  (edge_flag_q[g])
			);
			// Interrupt only in dual-edge mode, with status set and group enabled
			// Pins 11 and 12 belong to group A, pins 53 and 54 to group B
			assign DUAL_EDGE_IRQ[g] = edge_flag_q[g] & DUAL_EDGE_IRQ_MODE[g] &
				((g < 2) ? gpio_grp_a_smi_enable : gpio_grp_b_smi_enable);
			// Polarity still inverts the data readback
			assign DUAL_EDGE_READBACK[g] = edge_pin[g] ^ DUAL_EDGE_POLARITY[g];
		end
	endgenerate

	// Standby power-on flag, write one to clear
	// A pulse and a clear in one cycle leave it set
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			por_q <= 1'b0;
		end else if (EVT.standby_por) begin
			por_q <= 1'b1;
		end else if (wr_misc && IO_REQ.wdata[smi_pkg::MISC_POR]) begin
			por_q <= 1'b0;
		end
	end

	// System-on level of the previous cycle, for the turn-on edge
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sys_on_q <= 1'b0;
		end else begin
			sys_on_q <= ~SYSTEM_ON_N;
		end
	end

	// SCI when the system turns on while the power-on flag stands; drops with the flag
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			por_sci_q <= 1'b0;
		end else begin
			por_sci_q <= (~SYSTEM_ON_N & ~sys_on_q & por_q) | (por_sci_q & por_q);
		end
	end
	assign STANDBY_SCI = por_sci_q;

	// Named fields; GPIO groups include dual-edge interrupts from their pins
	assign mouse_irq_flag         = SRC.mouse;
	assign keybd_irq_flag         = SRC.keybd;
	assign infrared_edge_flag     = ir_q;
	assign bit3_event_flag        = bit3_q;
	assign kbc_port1_bit2         = SRC.kbc_port1_bit2;
	assign sleep_request_smi_flag = sleep_q;
	assign standby_por_flag       = por_q;
	assign dual_edge_flag         = edge_flag_q;
	assign group_irq_a            = SRC.gpio_grp_a | (|DUAL_EDGE_IRQ[1:0]);
	assign group_irq_b            = SRC.gpio_grp_b | (|DUAL_EDGE_IRQ[3:2]);

	// First status view bit by bit; bit 0 reserved, ring lives in wake status
	assign sts1[0] = 1'b0;
	assign sts1[1] = SRC.parport;
	assign sts1[2] = SRC.uart_b;
	assign sts1[3] = SRC.uart_a;
	assign sts1[4] = SRC.floppy;
	assign sts1[5] = group_irq_b;
	assign sts1[6] = group_irq_a;
	assign sts1[7] = SRC.watchdog;

	// Second status view and miscellaneous view
	assign sts2 = {sleep_request_smi_flag, 2'b00, kbc_port1_bit2, bit3_event_flag, infrared_edge_flag,
		keybd_irq_flag, mouse_irq_flag};
	assign misc = {3'b000, standby_por_flag, dual_edge_flag};

	// First group: status and enable; ring takes its wake status bit
	assign smi_term_1[0] = SRC.ring_pme & ring_smi_enable;
	assign smi_term_1[1] = sts1[1] & parport_smi_enable;
	assign smi_term_1[2] = sts1[2] & uart_b_smi_enable;
	assign smi_term_1[3] = sts1[3] & uart_a_smi_enable;
	assign smi_term_1[4] = sts1[4] & floppy_smi_enable;
	assign smi_term_1[5] = sts1[5] & gpio_grp_b_smi_enable;
	assign smi_term_1[6] = sts1[6] & gpio_grp_a_smi_enable;
	assign smi_term_1[7] = sts1[7] & watchdog_smi_enable;
	// Second group; consumer IR takes its wake status bit
	assign smi_term_2[0] = mouse_irq_flag & mouse_smi_enable;
	assign smi_term_2[1] = keybd_irq_flag & keybd_smi_enable;
	assign smi_term_2[2] = infrared_edge_flag & infrared_smi_enable;
	assign smi_term_2[3] = bit3_event_flag & bit3_smi_enable;
	assign smi_term_2[4] = kbc_port1_bit2 & kbc_pin_route_enable;
	assign smi_term_2[5] = SRC.cir_pme & consumer_ir_smi_enable;
	assign smi_term_2[6] = 1'b0;
	// Sleep-request flag has no enable bit of its own
	assign smi_term_2[7] = sleep_request_smi_flag;

	// Group output active while any term stands
	assign any_smi      = |{smi_term_2, smi_term_1};
	assign group_active = any_smi;

	// Routed copies: pin or serial slot 2 only while the output enable is set
	assign smi_pin_drive  = group_active & smi_output_enable & ~SERIAL_IRQ_SELECT;
	assign smi_slot_drive = group_active & smi_output_enable & SERIAL_IRQ_SELECT;

	// Open-drain pin: driven low when active, floats otherwise
	assign GROUP_MGMT_IRQ_N_O  = 1'b0;
	assign GROUP_MGMT_IRQ_N_OE = smi_pin_drive;
	assign SERIAL_IRQ2_REQ     = smi_slot_drive;
	// Wake logic sees the group output regardless of pin routing
	assign SMI_TO_WAKE         = group_active & smi_to_wake_enable;

	// Read mux; unmapped offsets read zero
	always_comb begin
		rdata_d = 8'h00;
		unique case (IO_REQ.addr)
			smi_pkg::SMI_STS1_OFS: rdata_d = sts1;
			smi_pkg::SMI_STATUS_2_OFS: rdata_d = sts2;
			smi_pkg::SMI_ENABLE_1_OFS:  rdata_d = en1_q;
			smi_pkg::SMI_ENABLE_2_OFS:  rdata_d = en2_q;
			smi_pkg::MISC_STS_OFS: rdata_d = misc;
			default:               rdata_d = 8'h00;
		endcase
	end

	// Read data registered; value captured before the read clears anything
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			IO_RDATA <= 8'h00;
		end else begin
			IO_RDATA <= IO_REQ.rd ? rdata_d : 8'h00;
		end
	end

	// Hit flag for reads that land on one of the five registers
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			IO_HIT <= 1'b0;
		end else begin
			IO_HIT <= IO_REQ.rd && (sel_sts1 || sel_sts2 || sel_en1 || sel_en2 || sel_misc);
		end
	end
endmodule

/* File: logic/smi_pkg.sv */
// Package for the group system-management interrupt block: offsets, fields, carriers
package smi_pkg;
	// Register offsets from the power block base (byte addresses on the host I/O port)
	localparam logic [7:0] SMI_STS1_OFS  = 8'h12;
	localparam logic [7:0] SMI_STATUS_2_OFS  = 8'h13;
	localparam logic [7:0] SMI_ENABLE_1_OFS   = 8'h14;
	localparam logic [7:0] SMI_ENABLE_2_OFS   = 8'h15;
	localparam logic [7:0] MISC_STS_OFS  = 8'h16;

	// Reset values
	localparam logic [7:0] EN1_RST       = 8'h00;
	localparam logic [7:0] EN2_RST       = 8'h00;
	localparam logic [7:0] MISC_RST      = 8'h00;

	// Second enable register fields
	localparam int EN2_MOUSE   = 0;
	localparam int EN2_KEYBD   = 1;
	localparam int EN2_IR      = 2;
	localparam int EN2_BIT3    = 3;
	localparam int EN2_KBC     = 4;
	localparam int EN2_CIR     = 5;
	localparam int EN2_TO_WAKE = 6;
	localparam int EN2_OUT     = 7;

	// Miscellaneous status fields
	localparam int MISC_POR    = 4;
	localparam int NUM_EDGE    = 4;

	// Sources reported at their origin, cleared there
	typedef struct packed {
		logic watchdog;
		logic gpio_grp_a;
		logic gpio_grp_b;
		logic floppy;
		logic uart_a;
		logic uart_b;
		logic parport;
		logic ring_pme;
		logic cir_pme;
		logic mouse;
		logic keybd;
		logic kbc_port1_bit2;
	} src_t;

	// Host I/O access
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} io_req_t;

	// Event pulses from neighbouring logic
	typedef struct packed {
		logic infrared_edge;
		logic bit3_event;
		logic sleep_request_smi;
		logic standby_por;
	} evt_t;
endpackage

/* File: logic/edge_flag.sv */
// One either-edge sticky status flag with write-one-to-clear
module edge_flag (
	// Clock and reset
	input  wire logic REF_CLK,
	input  wire logic RST_N,
	// Pin and host clear
	input  wire logic pin,
	input  wire logic clr,
	// Flag
	output logic      flag_q
);
	logic pin_q;
	logic seen_q;

	// Previous pin level; first sample after reset arms the detector only
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_q  <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			pin_q  <= pin;
			seen_q <= 1'b1;
		end
	end

	// Either transition sets; set wins over a clear in the same cycle
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			flag_q <= 1'b0;
		end else if (seen_q && (pin != pin_q)) begin
			flag_q <= 1'b1;
		end else if (clr) begin
			flag_q <= 1'b0;
		end
	end
endmodule

/* File: sim/smi_host_model.sv */
// Host-side model of the shared management interrupt line
module smi_host_model (
	// Open-drain pin from the device
	input  wire logic oe,
	input  wire logic o,
	// Level the host samples
	output logic      line
);
	timeunit 1ns;
	timeprecision 1ns;
	// Board pull-up holds the line high once the device lets go
	assign line = oe ? o : 1'b1;
endmodule

/* File: sim/smi_group_sva.sv */
// Port assertions for the group management interrupt collector
module smi_group_sva (
	// Clock and reset
	input  wire logic       REF_CLK,
	input  wire logic       RST_N,
	// Host access and sources
	input  smi_pkg::io_req_t IO_REQ,
	input  wire logic [7:0] IO_RDATA,
	input  wire logic       IO_HIT,
	input  smi_pkg::src_t   SRC,
	input  smi_pkg::evt_t   EVT,
	// Dual-edge pins
	input  wire logic       GPIO_PIN_11,
	input  wire logic       GPIO_PIN_12,
	input  wire logic       GPIO_PIN_53,
	input  wire logic       GPIO_PIN_54,
	input  wire logic [3:0] DUAL_EDGE_IRQ_MODE,
	input  wire logic [3:0] DUAL_EDGE_POLARITY,
	input  wire logic [3:0] DUAL_EDGE_READBACK,
	input  wire logic [3:0] DUAL_EDGE_IRQ,
	// Power and output routing
	input  wire logic       SYSTEM_ON_N,
	input  wire logic       STANDBY_SCI,
	input  wire logic       SERIAL_IRQ_SELECT,
	input  wire logic       GROUP_MGMT_IRQ_N_O,
	input  wire logic       GROUP_MGMT_IRQ_N_OE,
	input  wire logic       SERIAL_IRQ2_REQ
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rd13;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// Read of the second status register
	assign rd13 = IO_REQ.rd && IO_REQ.addr == 8'h13;
	property p_hit;
		IO_REQ.rd |=> IO_HIT == ($past(IO_REQ.addr) inside {[8'h12:8'h16]});
	endproperty
	a_hit: assert property (p_hit) else $error("hit flag wrong");
	property p_rbk;
		DUAL_EDGE_READBACK == ({GPIO_PIN_54, GPIO_PIN_53, GPIO_PIN_12, GPIO_PIN_11} ^ DUAL_EDGE_POLARITY);
	endproperty
	a_rbk: assert property (p_rbk) else $error("readback wrong");
	property p_misc;
		IO_REQ.rd && IO_REQ.addr == 8'h16 |=> IO_RDATA[7:5] == 3'h0;
	endproperty
	a_misc: assert property (p_misc) else $error("upper misc bits set");
	property p_pin;
		GROUP_MGMT_IRQ_N_OE |-> !SERIAL_IRQ_SELECT && !SERIAL_IRQ2_REQ && !GROUP_MGMT_IRQ_N_O;
	endproperty
	a_pin: assert property (p_pin) else $error("pin and slot both used");
	property p_dual;
		(DUAL_EDGE_IRQ & ~DUAL_EDGE_IRQ_MODE) == 4'h0;
	endproperty
	a_dual: assert property (p_dual) else $error("dual-edge irq without mode");
	property p_clr;
		rd13 && EVT[3:1] == 3'h0 ##1 rd13 |=> IO_RDATA[7] == 1'b0 && IO_RDATA[3:2] == 2'h0;
	endproperty
	a_clr: assert property (p_clr) else $error("flag kept after read");
	property p_src;
		rd13 |=> {IO_RDATA[6:4], IO_RDATA[1:0]} == {2'h0, $past(SRC.kbc_port1_bit2), $past(SRC.keybd), $past(SRC.mouse)};
	endproperty
	a_src: assert property (p_src) else $error("source bits wrong");
	property p_sci;
		$rose(STANDBY_SCI) |-> !SYSTEM_ON_N;
	endproperty
	a_sci: assert property (p_sci) else $error("sci while off");
endmodule
bind smi_group smi_group_sva i_sva (.REF_CLK, .RST_N, .IO_REQ, .IO_RDATA, .IO_HIT, .SRC, .EVT, .GPIO_PIN_11,
	.GPIO_PIN_12, .GPIO_PIN_53, .GPIO_PIN_54, .DUAL_EDGE_IRQ_MODE, .DUAL_EDGE_POLARITY, .DUAL_EDGE_READBACK,
	.DUAL_EDGE_IRQ, .SYSTEM_ON_N, .STANDBY_SCI, .SERIAL_IRQ_SELECT, .GROUP_MGMT_IRQ_N_O, .GROUP_MGMT_IRQ_N_OE,
	.SERIAL_IRQ2_REQ);

/* File: sim/test_smi_group.sv */
// Testbench for the group management interrupt collector
module test_smi_group;
	timeunit 1ns;
	timeprecision 1ns;
	logic             clk = 0, rst_n = 0, sel = 0, son_n = 1;
	smi_pkg::io_req_t req = '0;
	smi_pkg::src_t    src = '0;
	smi_pkg::evt_t    evt = '0;
	logic [3:0]       pins = '0, mode = '0, pol = '0, rbk, dirq;
	logic [7:0]       rdata;
	logic             hit, oe, o, ser, wake, sci, line;
	int               err_count = 0, total_checks = 0;
	always #5 clk = ~clk;
	smi_group i_dut (.REF_CLK(clk), .RST_N(rst_n), .IO_REQ(req), .IO_RDATA(rdata), .IO_HIT(hit), .SRC(src),
		.EVT(evt), .GPIO_PIN_11(pins[0]), .GPIO_PIN_12(pins[1]), .GPIO_PIN_53(pins[2]), .GPIO_PIN_54(pins[3]),
		.DUAL_EDGE_IRQ_MODE(mode), .DUAL_EDGE_POLARITY(pol), .DUAL_EDGE_READBACK(rbk), .DUAL_EDGE_IRQ(dirq),
		.SYSTEM_ON_N(son_n), .STANDBY_SCI(sci), .SERIAL_IRQ_SELECT(sel), .GROUP_MGMT_IRQ_N_O(o),
		.GROUP_MGMT_IRQ_N_OE(oe), .SERIAL_IRQ2_REQ(ser), .SMI_TO_WAKE(wake));
	smi_host_model i_host (.oe(oe), .o(o), .line(line));
	task automatic chk(input logic [7:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Inputs always move 1 ns after the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One host access plus an idle cycle, so strobes never retoggle in one step
	task automatic io(input logic r, input logic [7:0] a, d, exp);
		req = '{r, !r, a, d};
		cyc(1);
		if (r) chk(rdata, exp);
		req = '0;
		cyc(1);
	endtask
	task automatic t_regs;
		io(1, 8'h14, 0, 8'h00);
		io(1, 8'h15, 0, 8'h00);
		io(0, 8'h14, 8'hA5, 0);
		io(1, 8'h14, 0, 8'hA5);
		io(0, 8'h14, 8'h00, 0);
		io(1, 8'h20, 0, 8'h00);
	endtask
	task automatic t_sts2;
		src = 12'h007;
		evt = 4'hE;
		cyc(1);
		evt = '0;
		cyc(1);
		// Two reads back to back: the second sees the read-cleared flags gone
		req = '{1'b1, 1'b0, 8'h13, 8'h00};
		cyc(1);
		chk(rdata, 8'h9F);
		cyc(1);
		chk(rdata, 8'h13);
		req = '0;
		cyc(1);
		src = '0;
		cyc(2);
		io(1, 8'h13, 0, 8'h00);
	endtask
	task automatic t_group;
		logic [11:0] s [5] = '{12'h004, 12'h002, 12'h001, 12'h008, 12'h001};
		logic [7:0]  e [5] = '{8'h81, 8'h82, 8'h90, 8'hA0, 8'h80};
		logic [7:0]  v [3] = '{8'h04, 8'h08, 8'h80};
		io(0, 8'h15, 8'h80, 0);
		for (int i = 0; i < 8; i++) begin
			src = 12'h010 << i;
			io(0, 8'h14, 8'h01 << i, 0);
			chk(line, 1'b0);
			io(1, 8'h12, 0, (8'h01 << i) & 8'hFE);
			io(0, 8'h14, ~(8'h01 << i), 0);
			chk(line, 1'b1);
		end
		io(0, 8'h14, 8'h00, 0);
		for (int k = 0; k < 5; k++) begin
			src = s[k];
			io(0, 8'h15, e[k], 0);
			chk(line, k == 4);
		end
		src = 12'h004;
		io(0, 8'h15, 8'h41, 0);
		chk({wake, line}, 2'h3);
		sel = 1'b1;
		io(0, 8'h15, 8'h81, 0);
		chk({ser, line, wake}, 3'h6);
		sel = 1'b0;
		src = '0;
		io(1, 8'h13, 0, 8'h00);
		for (int j = 0; j < 3; j++) begin
			io(0, 8'h15, v[j] | 8'h80, 0);
			evt = 4'h8 >> j;
			cyc(1);
			evt = '0;
			cyc(1);
			chk(line, 1'b0);
			io(1, 8'h13, 0, v[j]);
			chk(line, 1'b1);
		end
	endtask
	task automatic t_edge;
		io(0, 8'h14, 8'h60, 0);
		pol = 4'h5;
		mode = 4'hF;
		for (int k = 0; k < 4; k++) begin
			repeat (2) begin
				pins[k] = ~pins[k];
				cyc(2);
				chk(rbk, pins ^ pol);
				chk(dirq, 4'h1 << k);
				io(1, 8'h16, 0, 8'h01 << k);
				io(0, 8'h16, 8'h00, 0);
				io(1, 8'h16, 0, 8'h01 << k);
				io(0, 8'h16, 8'h01 << k, 0);
				chk(dirq, 4'h0);
			end
		end
		// Mode set but group off, then group on but mode off: no interrupt either way
		io(0, 8'h14, 8'h00, 0);
		pins[0] = 1'b1;
		cyc(2);
		chk(dirq, 4'h0);
		io(1, 8'h16, 0, 8'h01);
		io(0, 8'h16, 8'h01, 0);
		io(0, 8'h14, 8'h60, 0);
		mode = 4'h0;
		pins[3] = 1'b1;
		cyc(2);
		chk(dirq, 4'h0);
		io(1, 8'h16, 0, 8'h08);
		io(0, 8'h16, 8'h08, 0);
		io(0, 8'h14, 8'h00, 0);
	endtask
	task automatic t_por;
		evt = 4'h1;
		cyc(1);
		evt = '0;
		cyc(1);
		io(1, 8'h16, 0, 8'h10);
		son_n = 1'b0;
		cyc(3);
		chk(sci, 1'b1);
		io(0, 8'h16, 8'h10, 0);
		chk(sci, 1'b0);
		io(1, 8'h16, 0, 8'h00);
	endtask
	task automatic test_done;
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence
	initial begin
		cyc(8);
		rst_n = 1'b1;
		cyc(2);
		chk(line, 1'b1);
		t_regs;
		t_sts2;
		t_group;
		t_edge;
		t_por;
		test_done;
	end
	// Watchdog: the run needs well under a thousand cycles
	initial begin
		#50us;
		err_count++;
		test_done;
	end
endmodule
